// ---- src/low_power_pkg.sv ----
// constants and types of the low-power mode controller
package low_power_pkg;

	// ********************************
	// apb register map
	// ********************************
	localparam logic [11:0] ctrl_off = 12'h000;
	localparam logic [11:0] wake_en_off = 12'h004;
	localparam logic [11:0] wdt_ctl_off = 12'h008;

	// ********************************
	// field positions
	// ********************************
	localparam int ctrl_wdt_en_bit = 0;
	localparam int ctrl_wdt_stop_bit = 1;
	localparam int stat_stop_bit = 0;
	localparam int stat_wdt_bit = 1;
	localparam int stat_sys_bit = 2;
	localparam int stat_mode_lsb = 4;

	// ********************************
	// reset values
	// ********************************
	localparam logic [1:0] ctrl_rst = 2'h0;
	localparam logic [7:0] wake_en_rst = 8'h00;
	localparam logic [2:0] flags_rst = 3'h0;

	// ********************************
	// recovery timing and reset vector
	// ********************************
	localparam logic [6:0] osc_hold_cycles = 7'h42;
	localparam logic [6:0] sys_hold_cycles = 7'h10;
	localparam logic [15:0] vector_hi_addr = 16'h0002;
	localparam logic [15:0] vector_lo_addr = 16'h0003;

	// ********************************
	// mode codes shown in status
	// ********************************
	localparam logic [1:0] mode_run = 2'h0;
	localparam logic [1:0] mode_halt = 2'h1;
	localparam logic [1:0] mode_stop = 2'h2;
	localparam logic [1:0] mode_recover = 2'h3;

	typedef enum logic [2:0] {
		st_run,
		st_halt,
		st_stop,
		st_rec_osc,
		st_rec_sys
	} pm_state_t;

endpackage

// ---- src/low_power_mode_control.sv ----
// low-power mode controller: sleep states, clock gating and stop recovery
//
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/1ns
// What this block does
// (RQ1) a deep-sleep instruction moves the block into deep sleep
// (RQ2) deep sleep stops the crystal, drives crystal in high and out low
// (RQ3) deep sleep gates the system clock and halts the cpu
// (RQ4) watchdog and its oscillator run in deep sleep only if configured
// (RQ5) brownout works in deep sleep only when its option bit allows
// (RQ6) other peripherals are held idle during deep sleep
// (RQ7) deep sleep is left only through the stop-recovery sequence
// (RQ8) software never uses deep sleep when fed by an external clock
// (RQ9) a light-sleep instruction moves the block into light sleep
// (RQ10) light sleep keeps crystal and system clock running
// (RQ11) light sleep stops the cpu and freezes its program counter
// (RQ12) light sleep keeps watchdog oscillator on, counter runs if enabled
// (RQ13) light sleep leaves all other peripherals running
// (RQ14) interrupt, watchdog, power-on, brownout or pin reset end light sleep
// (RQ15) recovery holds reset 66 watchdog ticks then 16 system clocks
// (RQ16) after recovery the cpu fetches the vector at 0002H and 0003H
// (RQ17) enabled gpio level change starts recovery; completion sets stop flag
// (RQ18) interrupt wake from light sleep resumes cpu at the halted point
module low_power_mode_control (
	input wire logic clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic cpu_stop_exec,
	input wire logic cpu_halt_exec,
	input wire logic irq_pending,
	input wire logic irq_enabled,
	input wire logic wdt_timeout_irq,
	input wire logic wdt_timeout_rst,
	input wire logic wdt_osc_tick,
	input wire logic por_event,
	input wire logic brownout_rst,
	input wire logic ext_reset_pin,
	input wire logic brownout_in_sleep_option,
	input wire logic [7:0] gpio_in,
	output logic cpu_run,
	output logic cpu_reset_n,
	output logic halt_resume,
	output logic vector_fetch,
	output logic [15:0] vector_addr_hi,
	output logic [15:0] vector_addr_lo,
	output logic wdt_irq_post,
	output logic xtal_osc_en,
	output logic crystal_in_pin_out,
	output logic crystal_in_pin_oe,
	output logic crystal_out_pin_out,
	output logic crystal_out_pin_oe,
	output logic sys_clk_en,
	output logic wdt_osc_en,
	output logic wdt_count_en,
	output logic brownout_en,
	output logic periph_idle
);

	// ********************************
	// declarations
	// ********************************
	low_power_pkg::pm_state_t state_reg;
	low_power_pkg::pm_state_t state_next;
	logic [1:0] ctrl_reg;
	logic [7:0] wake_en_reg;
	logic [2:0] watchdog_control_reg;
	logic [7:0] gpio_prev_reg;
	logic [6:0] count_reg;
	logic rec_from_stop_reg;
	logic rec_wdt_irq_reg;
	logic [31:0] prdata_reg;
	logic halt_resume_reg;
	logic vector_fetch_reg;
	logic wdt_irq_post_reg;
	logic wr_en;
	logic rd_setup;
	logic mapped;
	logic wdt_en;
	logic wdt_in_stop;
	logic sys_reset;
	logic gpio_wake;
	logic stop_wake;
	logic halt_wake;
	logic osc_done;
	logic sys_done;
	logic rec_done;
	logic [1:0] mode_code;
	logic [31:0] rd_value;

	// ********************************
	// apb slave
	// ********************************
	// address decode and strobes
	assign mapped = (paddr == low_power_pkg::ctrl_off)
		|| (paddr == low_power_pkg::wake_en_off)
		|| (paddr == low_power_pkg::wdt_ctl_off);
	assign wr_en = psel && penable && pwrite && mapped;
	assign rd_setup = psel && !penable && !pwrite;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata = prdata_reg;

	// read mux, unmapped reads zero
	always_comb begin
		rd_value = 32'h00000000;
		case (paddr)
			low_power_pkg::ctrl_off: begin
				rd_value[1:0] = ctrl_reg;
			end
			low_power_pkg::wake_en_off: begin
				rd_value[7:0] = wake_en_reg;
			end
			low_power_pkg::wdt_ctl_off: begin
				rd_value[2:0] = watchdog_control_reg;
				rd_value[low_power_pkg::stat_mode_lsb +: 2] = mode_code;
			end
			default: begin
				rd_value = 32'h00000000;
			end
		endcase
	end

	// read data captured in the setup cycle
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prdata_reg <= 32'h00000000;
		end else if (rd_setup) begin
			prdata_reg <= rd_value;
		end
	end

	// control register: watchdog enable and run-in-stop
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_reg <= low_power_pkg::ctrl_rst;
		end else if (wr_en && paddr == low_power_pkg::ctrl_off) begin
			ctrl_reg <= pwdata[1:0];
		end
	end

	// gpio wake source enables
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wake_en_reg <= low_power_pkg::wake_en_rst;
		end else if (wr_en && paddr == low_power_pkg::wake_en_off) begin
			wake_en_reg <= pwdata[7:0];
		end
	end

	assign wdt_en = ctrl_reg[low_power_pkg::ctrl_wdt_en_bit];
	assign wdt_in_stop = ctrl_reg[low_power_pkg::ctrl_wdt_stop_bit];

	// ********************************
	// wake and reset sources
	// ********************************
	// (RQ5) brownout gated by option
	assign sys_reset = por_event || ext_reset_pin
		|| (brownout_rst && brownout_en)
		|| (wdt_timeout_rst && state_reg != low_power_pkg::st_stop);

	// (RQ17) gpio edge detect
	assign gpio_wake = |((gpio_in ^ gpio_prev_reg) & wake_en_reg);
	assign stop_wake = gpio_wake || wdt_timeout_irq || wdt_timeout_rst;

	// (RQ14) light-sleep wake sources
	assign halt_wake = irq_pending || wdt_timeout_irq;

	// previous gpio levels
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			gpio_prev_reg <= 8'h00;
		end else begin
			gpio_prev_reg <= gpio_in;
		end
	end

	// ********************************
	// mode state machine
	// ********************************
	assign osc_done = wdt_osc_tick
		&& (count_reg == low_power_pkg::osc_hold_cycles - 7'h01);
	assign sys_done = count_reg == low_power_pkg::sys_hold_cycles - 7'h01;
	assign rec_done = (state_reg == low_power_pkg::st_rec_sys) && sys_done;

	// next state
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			low_power_pkg::st_run: begin
				if (sys_reset) begin
					state_next = low_power_pkg::st_rec_osc;
				// (RQ1) enter deep sleep
				end else if (cpu_stop_exec) begin
					state_next = low_power_pkg::st_stop;
				// (RQ9) enter light sleep
				end else if (cpu_halt_exec) begin
					state_next = low_power_pkg::st_halt;
				end
			end
			low_power_pkg::st_halt: begin
				if (sys_reset) begin
					state_next = low_power_pkg::st_rec_osc;
				// (RQ18) resume at halted point
				end else if (halt_wake) begin
					state_next = low_power_pkg::st_run;
				end
			end
			low_power_pkg::st_stop: begin
				// (RQ7) only exit is recovery
				if (sys_reset || stop_wake) begin
					state_next = low_power_pkg::st_rec_osc;
				end
			end
			low_power_pkg::st_rec_osc: begin
				// (RQ15) 66 watchdog ticks
				if (osc_done) begin
					state_next = low_power_pkg::st_rec_sys;
				end
			end
			low_power_pkg::st_rec_sys: begin
				// (RQ15) then 16 clocks
				if (sys_done) begin
					state_next = low_power_pkg::st_run;
				end
			end
			default: begin
				state_next = low_power_pkg::st_run;
			end
		endcase
	end

	// state register
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_reg <= low_power_pkg::st_run;
		end else begin
			state_reg <= state_next;
		end
	end

	// recovery cycle counter
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			count_reg <= 7'h00;
		end else if (state_reg != state_next) begin
			count_reg <= 7'h00;
		end else if (state_reg == low_power_pkg::st_rec_osc) begin
			if (wdt_osc_tick) begin
				count_reg <= count_reg + 7'h01;
			end
		end else if (state_reg == low_power_pkg::st_rec_sys) begin
			count_reg <= count_reg + 7'h01;
		end
	end

	// remembers why recovery started
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rec_from_stop_reg <= 1'b0;
			rec_wdt_irq_reg <= 1'b0;
		end else if (state_next == low_power_pkg::st_rec_osc
			&& state_reg != low_power_pkg::st_rec_osc) begin
			rec_from_stop_reg <= (state_reg == low_power_pkg::st_stop) && !sys_reset;
			rec_wdt_irq_reg <= (state_reg == low_power_pkg::st_stop)
				&& wdt_timeout_irq;
		end
	end

	// ********************************
	// event pulses to the cpu
	// ********************************
	// resume, vector fetch and post-recovery interrupt
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			halt_resume_reg <= 1'b0;
			vector_fetch_reg <= 1'b0;
			wdt_irq_post_reg <= 1'b0;
		end else begin
			// (RQ18) resume pulse
			halt_resume_reg <= (state_reg == low_power_pkg::st_halt)
				&& !sys_reset && halt_wake;
			// (RQ16) fetch reset vector
			vector_fetch_reg <= rec_done;
			wdt_irq_post_reg <= rec_done && rec_wdt_irq_reg && irq_enabled;
		end
	end

	assign halt_resume = halt_resume_reg;
	assign vector_fetch = vector_fetch_reg;
	assign wdt_irq_post = wdt_irq_post_reg;
	assign vector_addr_hi = low_power_pkg::vector_hi_addr;
	assign vector_addr_lo = low_power_pkg::vector_lo_addr;

	// ********************************
	// status flags
	// ********************************
	// set wins over write-one-to-clear
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			watchdog_control_reg <= low_power_pkg::flags_rst;
		end else begin
			// (RQ17) stop flag on completion
			if (rec_done && rec_from_stop_reg) begin
				watchdog_control_reg[low_power_pkg::stat_stop_bit] <= 1'b1;
			end else if (wr_en && paddr == low_power_pkg::wdt_ctl_off
				&& pwdata[low_power_pkg::stat_stop_bit]) begin
				watchdog_control_reg[low_power_pkg::stat_stop_bit] <= 1'b0;
			end
			if (wdt_timeout_rst || (state_reg == low_power_pkg::st_stop
				&& wdt_timeout_irq)) begin
				watchdog_control_reg[low_power_pkg::stat_wdt_bit] <= 1'b1;
			end else if (wr_en && paddr == low_power_pkg::wdt_ctl_off
				&& pwdata[low_power_pkg::stat_wdt_bit]) begin
				watchdog_control_reg[low_power_pkg::stat_wdt_bit] <= 1'b0;
			end
			if (rec_done && !rec_from_stop_reg) begin
				watchdog_control_reg[low_power_pkg::stat_sys_bit] <= 1'b1;
			end else if (wr_en && paddr == low_power_pkg::wdt_ctl_off
				&& pwdata[low_power_pkg::stat_sys_bit]) begin
				watchdog_control_reg[low_power_pkg::stat_sys_bit] <= 1'b0;
			end
		end
	end

	// ********************************
	// clock, cpu and peripheral gating
	// ********************************
	// outputs decoded per state
	always_comb begin
		mode_code = low_power_pkg::mode_run;
		cpu_run = 1'b1;
		cpu_reset_n = 1'b1;
		xtal_osc_en = 1'b1;
		sys_clk_en = 1'b1;
		wdt_osc_en = 1'b1;
		wdt_count_en = wdt_en;
		brownout_en = 1'b1;
		periph_idle = 1'b0;
		crystal_in_pin_out = 1'b0;
		crystal_in_pin_oe = 1'b0;
		crystal_out_pin_out = 1'b0;
		crystal_out_pin_oe = 1'b0;
		case (state_reg)
			low_power_pkg::st_run: begin
				mode_code = low_power_pkg::mode_run;
			end
			low_power_pkg::st_halt: begin
				mode_code = low_power_pkg::mode_halt;
				// (RQ11) cpu stopped
				cpu_run = 1'b0;
				// (RQ10) crystal and clock on
				xtal_osc_en = 1'b1;
				sys_clk_en = 1'b1;
				// (RQ12) watchdog oscillator on
				wdt_osc_en = 1'b1;
				wdt_count_en = wdt_en;
				// (RQ13) peripherals keep running
				periph_idle = 1'b0;
			end
			low_power_pkg::st_stop: begin
				mode_code = low_power_pkg::mode_stop;
				// (RQ3) clock and cpu stopped
				cpu_run = 1'b0;
				sys_clk_en = 1'b0;
				// (RQ2) crystal off, pins parked
				xtal_osc_en = 1'b0;
				crystal_in_pin_out = 1'b1;
				crystal_in_pin_oe = 1'b1;
				crystal_out_pin_out = 1'b0;
				crystal_out_pin_oe = 1'b1;
				// (RQ4) watchdog only if configured
				wdt_osc_en = wdt_en && wdt_in_stop;
				wdt_count_en = wdt_en && wdt_in_stop;
				// (RQ5) brownout per option bit
				brownout_en = brownout_in_sleep_option;
				// (RQ6) peripherals idle
				periph_idle = 1'b1;
			end
			low_power_pkg::st_rec_osc: begin
				mode_code = low_power_pkg::mode_recover;
				// (RQ15) held in reset
				cpu_run = 1'b0;
				cpu_reset_n = 1'b0;
				sys_clk_en = 1'b0;
				periph_idle = 1'b1;
			end
			low_power_pkg::st_rec_sys: begin
				mode_code = low_power_pkg::mode_recover;
				cpu_run = 1'b0;
				cpu_reset_n = 1'b0;
				periph_idle = 1'b1;
			end
			default: begin
				mode_code = low_power_pkg::mode_run;
			end
		endcase
	end

	// (RQ8) external clock feed is software's concern; deep sleep assumes a crystal

endmodule

// ---- tb/lpm_props.sv ----
// concurrent checks on the ports of the low-power mode controller
`timescale 1ns/1ns
module lpm_props (
	input wire logic clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic [11:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic cpu_stop_exec,
	input wire logic cpu_halt_exec,
	input wire logic irq_pending,
	input wire logic wdt_timeout_irq,
	input wire logic wdt_timeout_rst,
	input wire logic wdt_osc_tick,
	input wire logic por_event,
	input wire logic brownout_rst,
	input wire logic ext_reset_pin,
	input wire logic brownout_in_sleep_option,
	input wire logic [7:0] gpio_in,
	input wire logic cpu_run,
	input wire logic cpu_reset_n,
	input wire logic halt_resume,
	input wire logic vector_fetch,
	input wire logic [15:0] vector_addr_hi,
	input wire logic [15:0] vector_addr_lo,
	input wire logic wdt_irq_post,
	input wire logic xtal_osc_en,
	input wire logic crystal_in_pin_out,
	input wire logic crystal_in_pin_oe,
	input wire logic crystal_out_pin_out,
	input wire logic crystal_out_pin_oe,
	input wire logic sys_clk_en,
	input wire logic wdt_osc_en,
	input wire logic brownout_en,
	input wire logic periph_idle
);
	// ********************************
	// state decode and phase counters
	// ********************************
	logic in_stop, in_halt, in_osc, rst_req;
	int tick_cnt, sys_cnt;
	assign in_stop = !cpu_run && cpu_reset_n && !sys_clk_en;
	assign in_halt = !cpu_run && cpu_reset_n && sys_clk_en;
	assign in_osc = !cpu_reset_n && !sys_clk_en;
	assign rst_req = por_event || ext_reset_pin || brownout_rst || wdt_timeout_rst;
	// ticks of the oscillator phase, held until the cpu leaves reset
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst || cpu_reset_n) tick_cnt <= 0;
		else if (in_osc && wdt_osc_tick) tick_cnt <= tick_cnt + 1;
	end
	// clocks of the system-clock phase
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst || in_osc) sys_cnt <= 0;
		else if (!cpu_reset_n) sys_cnt <= sys_cnt + 1;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	// ********************************
	// assertions
	// ********************************
	stop_entry_a: assert property (cpu_run && cpu_reset_n && cpu_stop_exec && !rst_req
		|=> in_stop && !xtal_osc_en) else $error("deep sleep not entered");
	stop_pins_a: assert property (in_stop |-> crystal_in_pin_oe && crystal_in_pin_out
		&& crystal_out_pin_oe && !crystal_out_pin_out) else $error("crystal pins wrong");
	pin_release_a: assert property (!in_stop |-> !crystal_in_pin_oe
		&& !crystal_out_pin_oe) else $error("crystal pins driven outside stop");
	stop_idle_a: assert property (in_stop |-> periph_idle
		&& brownout_en == brownout_in_sleep_option) else $error("stop gating wrong");
	stop_stay_a: assert property (in_stop && !rst_req && !wdt_timeout_irq && $stable(gpio_in)
		|=> in_stop) else $error("stop left without wake");
	halt_entry_a: assert property (cpu_run && cpu_reset_n && cpu_halt_exec && !cpu_stop_exec
		&& !rst_req |=> in_halt && xtal_osc_en && wdt_osc_en && !periph_idle)
		else $error("light sleep wrong");
	halt_wake_a: assert property (in_halt && irq_pending && !rst_req |=> cpu_run
		##[0:1] halt_resume) else $error("no resume from light sleep");
	halt_reset_a: assert property (in_halt && rst_req |=> !cpu_reset_n)
		else $error("reset did not end light sleep");
	osc_phase_a: assert property ($rose(sys_clk_en) && !cpu_reset_n |-> tick_cnt == 66)
		else $error("oscillator phase length wrong");
	sys_phase_a: assert property ($rose(cpu_reset_n) |-> sys_cnt == 16)
		else $error("system clock phase length wrong");
	vec_fetch_a: assert property ($rose(cpu_reset_n) |-> ##[0:1] vector_fetch
		&& vector_addr_hi == 16'h0002 && vector_addr_lo == 16'h0003) else $error("vector fetch");
	apb_err_a: assert property (psel && penable && paddr == 12'h00C |-> pslverr && pready)
		else $error("unmapped access not refused");
	// main scenarios reached
	cover property (in_stop ##1 !cpu_reset_n);
	cover property (halt_resume);
	cover property (vector_fetch && wdt_irq_post);
endmodule

// ---- tb/cpu_model.sv ----
// cpu core model issuing sleep instructions and stepping its program counter
`timescale 1ns/1ns
module cpu_model #(
	parameter logic [15:0] vector_val = 16'h0100
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic req_stop,
	input wire logic req_halt,
	input wire logic cpu_run,
	input wire logic vector_fetch,
	output logic cpu_stop_exec,
	output logic cpu_halt_exec,
	output logic [15:0] pc
);
	// sleep opcodes only while the cpu is running
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cpu_stop_exec <= 1'b0;
			cpu_halt_exec <= 1'b0;
		end else begin
			cpu_stop_exec <= req_stop && cpu_run;
			cpu_halt_exec <= req_halt && cpu_run;
		end
	end
	// counter steps with cpu clock, vector reload
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) pc <= 16'h0000;
		else if (vector_fetch) pc <= vector_val;
		else if (cpu_run) pc <= pc + 16'h0001;
	end
endmodule

// ---- tb/tb_top.sv ----
// self-checking bench of the low-power mode controller
`timescale 1ns/1ns
module tb_top;
	logic clk, nrst, psel, penable, pwrite, irq_pending, irq_enabled, wdt_timeout_irq, e;
	logic wdt_osc_tick, ext_reset_pin, brownout_in_sleep_option, req_stop, req_halt;
	logic pready, pslverr, cpu_run, cpu_reset_n, halt_resume, vector_fetch, wdt_irq_post;
	logic xtal_osc_en, crystal_in_pin_out, crystal_in_pin_oe, crystal_out_pin_out;
	logic crystal_out_pin_oe, sys_clk_en, wdt_osc_en, wdt_count_en, brownout_en;
	logic periph_idle, cpu_stop_exec, cpu_halt_exec;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [7:0] gpio_in;
	logic [15:0] vector_addr_hi, vector_addr_lo, pc, p0;
	int n_mismatch, samples_checked, n_vf, n_hr, n_wp, tick_div;
	// ********************************
	// design, cpu model, clock
	// ********************************
	low_power_mode_control dut_u (.*, .por_event(1'b0), .brownout_rst(1'b0),
		.wdt_timeout_rst(1'b0));
	cpu_model cpu_u (.*);
	// free-running system clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// watchdog oscillator tick every fourth clock, pulse counters
	always @(posedge clk) begin
		tick_div <= tick_div + 1;
		wdt_osc_tick <= (tick_div % 4 == 3);
		n_vf <= n_vf + vector_fetch;
		n_hr <= n_hr + halt_resume;
		n_wp <= n_wp + wdt_irq_post;
	end
	// ********************************
	// shared tasks
	// ********************************
	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task summarize;
		$display("checked %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (pready !== 1'b1 && i < 50);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i >= 50) begin
			n_mismatch++;
			$display("FAIL %0t bus wait ran out", $time);
			summarize();
		end
	endtask
	task rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(q, exp, "read data");
		chk(e, 1'b0, "read error");
	endtask
	task automatic wait_lvl(ref logic s, input logic v);
		int i;
		for (i = 0; i < 2000 && s !== v; i++) @(posedge clk);
		if (s !== v) begin
			n_mismatch++;
			$display("FAIL %0t wait ran out", $time);
			summarize();
		end
	endtask
	task sleep(input logic stop);
		@(posedge clk);
		req_stop <= stop;
		req_halt <= !stop;
		@(posedge clk);
		req_stop <= 1'b0;
		req_halt <= 1'b0;
		wait_lvl(cpu_run, 1'b0);
		@(negedge clk);
		p0 = pc;
	endtask
	task recover;
		wait_lvl(cpu_reset_n, 1'b0);
		wait_lvl(cpu_run, 1'b1);
		repeat (3) @(negedge clk);
	endtask
	// ********************************
	// scenarios
	// ********************************
	task t_regs;
		rd(12'h000, 32'h0);
		rd(12'h004, 32'h0);
		rd(12'h008, 32'h0);
		apb(1'b1, 12'h000, 32'hFFFFFFFF);
		rd(12'h000, 32'h3);
		apb(1'b1, 12'h004, 32'h000001FF);
		rd(12'h004, 32'hFF);
		apb(1'b0, 12'h00C, 32'h0);
		chk(e, 32'h1, "unmapped error");
		chk(q, 32'h0, "unmapped data");
		$display("test regs done");
	endtask
	task t_halt;
		sleep(1'b0);
		chk({xtal_osc_en, sys_clk_en, wdt_osc_en, wdt_count_en, periph_idle, cpu_run},
			6'b111100, "halt levels");
		rd(12'h008, 32'h10);
		chk(pc, p0, "pc in halt");
		@(posedge clk);
		irq_pending <= 1'b1;
		wait_lvl(cpu_run, 1'b1);
		@(posedge clk);
		irq_pending <= 1'b0;
		repeat (2) @(negedge clk);
		chk(n_hr, 1, "resume pulse");
		$display("test halt done");
	endtask
	task t_halt_rst;
		sleep(1'b0);
		@(posedge clk);
		ext_reset_pin <= 1'b1;
		repeat (4) @(posedge clk);
		ext_reset_pin <= 1'b0;
		recover();
		rd(12'h008, 32'h4);
		apb(1'b1, 12'h008, 32'h7);
		rd(12'h008, 32'h0);
		$display("test halt reset done");
	endtask
	task t_stop_gpio;
		apb(1'b1, 12'h000, 32'h0);
		apb(1'b1, 12'h004, 32'h1);
		sleep(1'b1);
		chk({xtal_osc_en, sys_clk_en, wdt_osc_en, wdt_count_en, brownout_en, periph_idle},
			6'b000001, "stop levels");
		chk({crystal_in_pin_oe, crystal_in_pin_out, crystal_out_pin_oe, crystal_out_pin_out},
			4'b1110, "crystal pins");
		rd(12'h008, 32'h20);
		@(posedge clk);
		gpio_in <= 8'h02;
		repeat (20) @(negedge clk);
		chk({cpu_run, cpu_reset_n, pc}, {2'b01, p0}, "stop held");
		@(posedge clk);
		gpio_in <= 8'h03;
		recover();
		chk(n_vf, 2, "vector fetch");
		rd(12'h008, 32'h1);
		apb(1'b1, 12'h008, 32'h1);
		$display("test stop gpio done");
	endtask
	task t_stop_wdt;
		apb(1'b1, 12'h000, 32'h3);
		@(posedge clk);
		brownout_in_sleep_option <= 1'b1;
		irq_enabled <= 1'b1;
		sleep(1'b1);
		chk({wdt_osc_en, wdt_count_en, brownout_en}, 3'b111, "stop keep alive");
		@(posedge clk);
		wdt_timeout_irq <= 1'b1;
		@(posedge clk);
		wdt_timeout_irq <= 1'b0;
		recover();
		chk(n_vf, 3, "watchdog wake fetch");
		chk(n_wp, 1, "watchdog wake irq");
		rd(12'h008, 32'h3);
		$display("test stop watchdog done");
	endtask
	// ********************************
	// main sequence
	// ********************************
	initial begin
		{nrst, psel, penable, pwrite, irq_pending, irq_enabled, wdt_timeout_irq} = 7'h00;
		{wdt_osc_tick, ext_reset_pin, brownout_in_sleep_option, req_stop, req_halt} = 5'h00;
		{paddr, pwdata, gpio_in} = 52'h0;
		{n_mismatch, samples_checked, n_vf, n_hr, n_wp, tick_div} = '0;
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		t_regs();
		t_halt();
		t_halt_rst();
		t_stop_gpio();
		t_stop_wdt();
		summarize();
	end
endmodule
bind low_power_mode_control lpm_props chk_u (.*);
